// *** sfe_cmd_if.sv ***
`timescale 1ns/10ps
// decoded frame handed from the shifter to the sequencer
interface sfe_cmd_if;
	logic frame_end;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [5:0] bit_count;

	modport shifter (output frame_end, output opcode, output addr, output bit_count);
	modport seq (input frame_end, input opcode, input addr, input bit_count);
endinterface

// *** sfe_core.sv ***
`timescale 1ns/10ps
`include "sfe_defines.svh"

// Notes on behaviour
// R1: sector erase 20h fills sector with FFh
// R2: erase needs write-enable latch set first
// R3: host sends opcode plus three address bytes
// R4: chip select rises right after address
// R5: host holds chip select low all sequence
// R6: busy flag high during self-timed cycle
// R7: latch cleared before erase cycle ends
// R8: protected region blocks sector/block erase; code reads only the mask bit of the 32 KB half holding the address
// R9: 52h erases 32 KB half block
// R10: D8h erases 64 KB block
// R11: C7h or 60h erases whole array
// R12: chip erase, sleep end after opcode
// R13: chip erase only with protect bits zero
// R14: erase also accepted in quad mode
// R15: B9h alone enters sleep, blocks writes
// R16: deselect without cycle means plain standby
// R17: sleep entered after delay past chip select
// R18: in sleep only wake command is heard
// R19: sleep rejected while a cycle runs
// R20: power-up always lands in standby
// R21: soft reset pair does not wake
// R22: ABh wakes, then recovery time
// R23: erase without latch does nothing
module sfe_core #(
	parameter int SECTOR_CYC = `SFE_SECTOR_ERASE_TIME_US * `SFE_CLK_MHZ,
	parameter int HALF_CYC = `SFE_HALF_BLOCK_ERASE_TIME_US * `SFE_CLK_MHZ,
	parameter int BLOCK_CYC = `SFE_BLOCK_ERASE_TIME_US * `SFE_CLK_MHZ,
	parameter int CHIP_CYC = `SFE_CHIP_ERASE_TIME_US * `SFE_CLK_MHZ
) (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic CS_N_I,
	input wire logic SCK_RISE_I,
	input wire logic [3:0] DQ_I,
	input wire logic [3:0] PROTECT_BITS_I,
	input wire logic [5:0] PROTECTED_MASK_I,
	output logic BUSY_FLAG_O,
	output logic WRITE_ENABLE_LATCH_O,
	output logic QUAD_MODE_O,
	output logic DEEP_SLEEP_O,
	output logic STANDBY_O,
	output logic ERASE_START_O,
	output logic [2:0] ERASE_KIND_O,
	output logic [23:0] ERASE_ADDR_O,
	output logic [7:0] ERASE_FILL_O
);
	// ==========================================================
	// reset release
	logic rst_s1_r;
	logic rst_n;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// ==========================================================
	// serial front end
	sfe_cmd_if cmd ();
	logic quad_r;

	sfe_shifter u_shifter (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.cs_n_i(CS_N_I),
		.sck_rise_i(SCK_RISE_I),
		.quad_i(quad_r),
		.dq_i(DQ_I),
		.cmd(cmd.shifter)
	);

	// ==========================================================
	// decode
	function automatic sfe_pkg::sfe_kind_t kind_of(input logic [7:0] op);
		unique case (op)
			`SFE_OP_SECTOR_ERASE: kind_of = sfe_pkg::SFE_KIND_SECTOR;
			`SFE_OP_HALF_BLOCK_ERASE: kind_of = sfe_pkg::SFE_KIND_HALF;
			`SFE_OP_BLOCK_ERASE: kind_of = sfe_pkg::SFE_KIND_BLOCK;
			`SFE_OP_CHIP_ERASE_A, `SFE_OP_CHIP_ERASE_B: kind_of = sfe_pkg::SFE_KIND_CHIP;
			default: kind_of = sfe_pkg::SFE_KIND_NONE;
		endcase
	endfunction

	// region index in 64 KB units of two halves: protected mask bit per 32 KB half
	// plus sector coverage through the half that holds it
	function automatic logic region_locked(input logic [23:0] a, input logic [5:0] m);
		region_locked = m[{1'b0, a[16:15]}];
	endfunction

	logic busy;
	logic wel_r;
	sfe_pkg::sfe_pwr_t pwr_r;
	logic [15:0] pwr_cnt_r;
	logic opcode_only;
	logic addr_frame;
	sfe_pkg::sfe_kind_t kind_at_opcode;
	sfe_pkg::sfe_kind_t kind_at_addr;
	logic awake;
	logic erase_go;
	logic sleep_go;
	logic wake_go;
	logic [31:0] load;
	logic locked;

	assign opcode_only = cmd.frame_end && cmd.bit_count == `SFE_OPCODE_BITS; // [R12]
	assign addr_frame = cmd.frame_end && cmd.bit_count == `SFE_ADDR_END_BITS; // [R4]
	assign kind_at_opcode = kind_of(cmd.opcode);
	assign kind_at_addr = kind_of(cmd.opcode);
	assign awake = (pwr_r == sfe_pkg::SFE_PWR_STANDBY);
	assign locked = region_locked(cmd.addr, PROTECTED_MASK_I);

	// ==========================================================
	// erase launch
	always_comb begin
		erase_go = 1'b0;
		if (awake && !busy && wel_r) begin // [R2] [R23] [R15]
			if (addr_frame && kind_at_addr != sfe_pkg::SFE_KIND_NONE
				&& kind_at_addr != sfe_pkg::SFE_KIND_CHIP && !locked) begin // [R8] [R14]
				erase_go = 1'b1;
			end
			if (opcode_only && kind_at_opcode == sfe_pkg::SFE_KIND_CHIP
				&& PROTECT_BITS_I == 4'h0) begin // [R11] [R13]
				erase_go = 1'b1;
			end
		end
	end

	always_comb begin
		unique case (kind_of(cmd.opcode))
			sfe_pkg::SFE_KIND_SECTOR: load = 32'(SECTOR_CYC); // [R1]
			sfe_pkg::SFE_KIND_HALF: load = 32'(HALF_CYC); // [R9]
			sfe_pkg::SFE_KIND_BLOCK: load = 32'(BLOCK_CYC); // [R10]
			sfe_pkg::SFE_KIND_CHIP: load = 32'(CHIP_CYC);
			default: load = 32'h0000_0001;
		endcase
	end

	sfe_cycle_timer u_timer (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.start_i(erase_go),
		.load_i(load),
		.busy_o(busy)
	);

	// ==========================================================
	// write enable latch, quad mode
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			wel_r <= 1'b0;
		end else if (erase_go) begin
			wel_r <= 1'b0; // [R7]
		end else if (awake && !busy && opcode_only && cmd.opcode == `SFE_OP_WRITE_ENABLE) begin
			wel_r <= 1'b1; // [R2]
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			quad_r <= 1'b0;
		end else if (awake && !busy && opcode_only && cmd.opcode == `SFE_OP_QUAD_ENTER) begin
			quad_r <= 1'b1; // [R14]
		end
	end

	// ==========================================================
	// power state
	// soft reset opcodes are not decoded here at all, so they never touch sleep
	assign sleep_go = awake && !busy && opcode_only && cmd.opcode == `SFE_OP_DEEP_SLEEP; // [R19]
	assign wake_go = pwr_r == sfe_pkg::SFE_PWR_SLEEP && opcode_only
		&& cmd.opcode == `SFE_OP_WAKE_ID; // [R18] [R21]

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			pwr_r <= sfe_pkg::SFE_PWR_STANDBY; // [R20]
			pwr_cnt_r <= 16'h0000;
		end else begin
			unique case (pwr_r)
				sfe_pkg::SFE_PWR_STANDBY: begin
					if (sleep_go) begin // [R15]
						pwr_r <= sfe_pkg::SFE_PWR_ENTERING;
						pwr_cnt_r <= 16'(`SFE_SLEEP_ENTRY_CYC);
					end
				end
				sfe_pkg::SFE_PWR_ENTERING: begin
					if (pwr_cnt_r <= 16'h0001) begin
						pwr_r <= sfe_pkg::SFE_PWR_SLEEP; // [R17]
					end
					pwr_cnt_r <= pwr_cnt_r - 16'h0001;
				end
				sfe_pkg::SFE_PWR_SLEEP: begin
					if (wake_go) begin // [R22]
						pwr_r <= sfe_pkg::SFE_PWR_WAKING;
						pwr_cnt_r <= 16'(`SFE_WAKE_RECOVERY_CYC);
					end
				end
				sfe_pkg::SFE_PWR_WAKING: begin
					if (pwr_cnt_r <= 16'h0001) begin
						pwr_r <= sfe_pkg::SFE_PWR_STANDBY;
					end
					pwr_cnt_r <= pwr_cnt_r - 16'h0001;
				end
			endcase
		end
	end

	// ==========================================================
	// outputs
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ERASE_START_O <= 1'b0;
			ERASE_KIND_O <= 3'h0;
			ERASE_ADDR_O <= 24'h00_0000;
		end else begin
			ERASE_START_O <= erase_go;
			if (erase_go) begin
				ERASE_KIND_O <= kind_of(cmd.opcode);
				ERASE_ADDR_O <= cmd.addr;
			end
		end
	end

	assign ERASE_FILL_O = `SFE_ERASED_BYTE; // [R1]
	assign BUSY_FLAG_O = busy; // [R6]
	assign WRITE_ENABLE_LATCH_O = wel_r;
	assign QUAD_MODE_O = quad_r;
	assign DEEP_SLEEP_O = (pwr_r == sfe_pkg::SFE_PWR_SLEEP);
	assign STANDBY_O = CS_N_I && !busy && awake; // [R16]

	// ==========================================================
	// checks
	chk_erase_needs_latch: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R2]
		erase_go |-> wel_r)
		else $error("erase started without write enable latch");
	chk_no_latch_idle: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R23]
		(!wel_r && !busy && cmd.frame_end) |=> !busy)
		else $error("erase ran without latch");
	chk_busy_after_start: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R6]
		erase_go |=> busy [*2])
		else $error("busy not raised after erase start");
	chk_latch_cleared: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R7]
		erase_go |=> !wel_r)
		else $error("latch not cleared in erase");
	chk_chip_protect: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R13]
		(erase_go && kind_of(cmd.opcode) == sfe_pkg::SFE_KIND_CHIP) |-> PROTECT_BITS_I == 4'h0)
		else $error("chip erase with protection set");
	chk_region_protect: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R8]
		(erase_go && addr_frame) |-> !locked)
		else $error("protected region erased");
	chk_frame_length: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R4]
		erase_go |-> (cmd.bit_count == `SFE_OPCODE_BITS || cmd.bit_count == `SFE_ADDR_END_BITS))
		else $error("erase from bad framing");
	chk_sleep_delay: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R17]
		sleep_go |=> !DEEP_SLEEP_O [*8])
		else $error("sleep entered too early");
	chk_sleep_busy: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R19]
		(busy && cmd.frame_end) |=> pwr_r == $past(pwr_r))
		else $error("sleep accepted during cycle");
	chk_sleep_no_erase: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R15]
		DEEP_SLEEP_O |-> !erase_go)
		else $error("erase in sleep");

	// ==========================================================
	// checks: launch and latch
	// pulse outputs lag the launch by one registered stage
	chk_start_one_cycle: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R6]
		ERASE_START_O |=> !ERASE_START_O)
		else $error("erase start pulse longer than one cycle");
	chk_start_after_go: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R6]
		erase_go |=> ERASE_START_O)
		else $error("erase start pulse missing");
	chk_busy_from_launch: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R6]
		$rose(busy) |-> $past(erase_go))
		else $error("busy raised without a launch");
	chk_wel_on_decode: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R2]
		(awake && !busy && opcode_only && cmd.opcode == `SFE_OP_WRITE_ENABLE)
		|=> WRITE_ENABLE_LATCH_O)
		else $error("write enable not latched");
	chk_wel_rise_cause: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R2]
		$rose(wel_r) |-> $past(opcode_only && cmd.opcode == `SFE_OP_WRITE_ENABLE))
		else $error("latch set by another command");
	chk_chip_one_byte: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R12]
		(erase_go && kind_at_opcode == sfe_pkg::SFE_KIND_CHIP) |-> opcode_only)
		else $error("chip erase from a long frame");
	chk_addr_frame_len: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R4]
		(erase_go && kind_at_addr != sfe_pkg::SFE_KIND_CHIP) |-> addr_frame)
		else $error("region erase from a bad frame");
	chk_addr_capture: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R1]
		erase_go |=> ERASE_ADDR_O == $past(cmd.addr))
		else $error("erase address not captured");
	chk_kind_capture: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R9]
		erase_go |=> ERASE_KIND_O == $past(kind_at_addr))
		else $error("erase kind not captured");

	// ==========================================================
	// checks: power state, quad mode
	// delays are the 30-cycle loads plus one for the state flop
	chk_sleep_enter_time: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R17]
		sleep_go |-> ##31 DEEP_SLEEP_O)
		else $error("sleep not entered after delay");
	chk_sleep_hold: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R18]
		(DEEP_SLEEP_O && !wake_go) |=> DEEP_SLEEP_O)
		else $error("sleep left without wake command");
	chk_sleep_exit_cause: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R21]
		$fell(DEEP_SLEEP_O) |-> $past(wake_go))
		else $error("sleep ended by another command");
	chk_wake_leaves: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R22]
		wake_go |=> !DEEP_SLEEP_O)
		else $error("wake command did not leave sleep");
	chk_wake_quiet: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R22]
		wake_go |=> !awake [*8])
		else $error("commands heard during recovery");
	chk_wake_recovery: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R22]
		wake_go |-> ##31 awake)
		else $error("standby not reached after recovery");
	chk_standby_stays: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R15]
		(awake && !sleep_go) |=> awake)
		else $error("standby left without sleep command");
	chk_sleep_keeps_wel: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R15]
		!awake |=> $stable(wel_r))
		else $error("latch changed while not awake");
	chk_quad_sticky: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R14]
		QUAD_MODE_O |=> QUAD_MODE_O)
		else $error("quad mode dropped");
	chk_sleep_no_standby: assert property (@(posedge CLK_I) disable iff (!rst_n) // [R16]
		DEEP_SLEEP_O |-> !STANDBY_O)
		else $error("standby shown in sleep");

	cov_sector: cover property (@(posedge CLK_I) disable iff (!rst_n)
		erase_go && kind_of(cmd.opcode) == sfe_pkg::SFE_KIND_SECTOR);
	cov_chip: cover property (@(posedge CLK_I) disable iff (!rst_n)
		erase_go && kind_of(cmd.opcode) == sfe_pkg::SFE_KIND_CHIP);
	cov_sleep: cover property (@(posedge CLK_I) disable iff (!rst_n) DEEP_SLEEP_O);
	cov_wake: cover property (@(posedge CLK_I) disable iff (!rst_n) wake_go);
	cov_quad_erase: cover property (@(posedge CLK_I) disable iff (!rst_n) erase_go && quad_r);
endmodule

// *** sfe_cycle_timer.sv ***
`timescale 1ns/10ps

module sfe_cycle_timer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [31:0] load_i,
	output logic busy_o
);
	logic [31:0] count_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_r <= 32'h0000_0000;
		end else if (start_i) begin
			count_r <= load_i;
		end else if (count_r != 32'h0000_0000) begin
			count_r <= count_r - 32'h0000_0001;
		end
	end

	assign busy_o = (count_r != 32'h0000_0000);
endmodule

// *** sfe_defines.svh ***
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH

// ==========================================================
// opcodes
`define SFE_OP_SECTOR_ERASE 8'h20
`define SFE_OP_HALF_BLOCK_ERASE 8'h52
`define SFE_OP_BLOCK_ERASE 8'hD8
`define SFE_OP_CHIP_ERASE_A 8'hC7
`define SFE_OP_CHIP_ERASE_B 8'h60
`define SFE_OP_DEEP_SLEEP 8'hB9
`define SFE_OP_WAKE_ID 8'hAB
`define SFE_OP_WRITE_ENABLE 8'h06
`define SFE_OP_QUAD_ENTER 8'h38
`define SFE_OP_SOFT_RESET_ARM 8'h66
`define SFE_OP_SOFT_RESET 8'h99

// ==========================================================
// framing
`define SFE_OPCODE_BITS 6'd8
`define SFE_ADDR_END_BITS 6'd32
`define SFE_ERASED_BYTE 8'hFF

// ==========================================================
// timing, clock 10 MHz
`define SFE_CLK_MHZ 10
`define SFE_SECTOR_ERASE_TIME_US 40000
`define SFE_HALF_BLOCK_ERASE_TIME_US 100000
`define SFE_BLOCK_ERASE_TIME_US 150000
`define SFE_CHIP_ERASE_TIME_US 600000
`define SFE_SLEEP_ENTRY_DELAY_US 3
`define SFE_WAKE_RECOVERY_TIME_US 3
`define SFE_SLEEP_ENTRY_CYC (`SFE_SLEEP_ENTRY_DELAY_US * `SFE_CLK_MHZ)
`define SFE_WAKE_RECOVERY_CYC (`SFE_WAKE_RECOVERY_TIME_US * `SFE_CLK_MHZ)

`endif

// *** sfe_host_model.sv ***
`timescale 1ns/10ps

module sfe_host_model (
	input wire logic clk_i,
	output logic cs_n_o,
	output logic sck_rise_o,
	output logic [3:0] dq_o
);
	// ==========================================================
	// host state, set by the bench
	logic quad_r = 1'b0;
	int gap_r = 0;

	initial begin
		cs_n_o = 1'b1;
		sck_rise_o = 1'b0;
		dq_o = 4'h0;
	end

	// ==========================================================
	// one frame, msb first; chip select low over every bit
	task automatic send(input logic [31:0] data, input int nbits, input int hold);
		int step;
		step = quad_r ? 4 : 1;
		@(negedge clk_i);
		cs_n_o = 1'b0;
		for (int i = nbits; i > 0; i -= step) begin
			// idle lines toggle so a stale level never looks valid
			dq_o = quad_r ? data[i-1 -: 4] : {~dq_o[3:1], data[i-1]};
			sck_rise_o = 1'b1;
			@(negedge clk_i);
			// strobe stays up across back-to-back bits, one change per step
			if (gap_r > 0) begin
				sck_rise_o = 1'b0;
				repeat (gap_r) @(negedge clk_i);
			end
		end
		// deselect after the last bit, once its gap_r idle cycles have passed
		sck_rise_o = 1'b0;
		cs_n_o = 1'b1;
		dq_o = ~dq_o;
		// chip select held high for recovery before the next frame
		repeat (hold) @(negedge clk_i);
	endtask
endmodule

// *** sfe_pkg.sv ***
package sfe_pkg;
	typedef enum logic [2:0] {
		SFE_KIND_NONE = 3'h0,
		SFE_KIND_SECTOR = 3'h1,
		SFE_KIND_HALF = 3'h2,
		SFE_KIND_BLOCK = 3'h3,
		SFE_KIND_CHIP = 3'h4
	} sfe_kind_t;

	typedef enum logic [1:0] {
		SFE_PWR_STANDBY = 2'b00,
		SFE_PWR_ENTERING = 2'b01,
		SFE_PWR_SLEEP = 2'b11,
		SFE_PWR_WAKING = 2'b10
	} sfe_pwr_t;
endpackage

// *** sfe_shifter.sv ***
`timescale 1ns/10ps
`include "sfe_defines.svh"

module sfe_shifter (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic sck_rise_i,
	input wire logic quad_i,
	input wire logic [3:0] dq_i,
	sfe_cmd_if.shifter cmd
);
	logic cs_n_d_r;
	logic [31:0] shift_r;
	logic [5:0] count_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_n_d_r <= 1'b1;
		end else begin
			cs_n_d_r <= cs_n_i;
		end
	end

	// quad mode moves a nibble per edge, otherwise one bit on dq0
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_r <= 32'h0000_0000;
			count_r <= 6'h00;
		end else if (cs_n_i) begin
			count_r <= 6'h00;
		end else if (sck_rise_i && count_r < 6'd40) begin
			if (quad_i) begin
				shift_r <= {shift_r[27:0], dq_i};
				count_r <= count_r + 6'd4;
			end else begin
				shift_r <= {shift_r[30:0], dq_i[0]};
				count_r <= count_r + 6'd1;
			end
		end
	end

	always_comb begin
		cmd.frame_end = cs_n_i && !cs_n_d_r;
		cmd.bit_count = count_r;
		cmd.opcode = (count_r >= `SFE_ADDR_END_BITS) ? shift_r[31:24] : shift_r[7:0];
		cmd.addr = shift_r[23:0];
	end
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps

module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] prot = 4'h0;
	logic [5:0] mask = 6'h00;
	logic cs_n, sck_rise, busy, write_enable_latch, quad, sleep, stby, start;
	logic [3:0] dq;
	logic [2:0] kind;
	logic [23:0] addr;
	logic [7:0] fill;
	int mismatches = 0;
	int n_compared = 0;
	int n_start = 0;
	int busy_cyc = 0;

	always #50 clk = ~clk;

	sfe_host_model sfe_host_model_inst (.clk_i(clk), .cs_n_o(cs_n), .sck_rise_o(sck_rise),
		.dq_o(dq));

	// distinct lengths tell the erase kinds apart
	sfe_core #(.SECTOR_CYC(20), .HALF_CYC(24), .BLOCK_CYC(28), .CHIP_CYC(200)) sfe_core_inst (
		.CLK_I(clk), .RESETN_I(rst_n), .CS_N_I(cs_n), .SCK_RISE_I(sck_rise), .DQ_I(dq),
		.PROTECT_BITS_I(prot), .PROTECTED_MASK_I(mask), .BUSY_FLAG_O(busy),
		.WRITE_ENABLE_LATCH_O(write_enable_latch), .QUAD_MODE_O(quad), .DEEP_SLEEP_O(sleep),
		.STANDBY_O(stby), .ERASE_START_O(start), .ERASE_KIND_O(kind),
		.ERASE_ADDR_O(addr), .ERASE_FILL_O(fill));

	always @(posedge clk) begin
		if (start === 1'b1) n_start <= n_start + 1;
		if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
	end

	// ==========================================================
	// checking and closing
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic give_verdict;
		if (mismatches == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wait_idle;
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 400) begin
			@(negedge clk);
			k++;
		end
		if (k == 400) begin
			mismatches++;
			$display("[ERR] busy expected 0 seen %b", busy);
			give_verdict();
		end
	endtask

	// ==========================================================
	// command tasks
	task automatic send(input logic [31:0] data, input int nbits, input int hold);
		sfe_host_model_inst.send(data, nbits, hold);
	endtask

	task automatic write_enable_cmd;
		send(32'h0000_0006, 8, 40);
		chk("write_enable_latch", 1, write_enable_latch);
	endtask

	// len 0 means the frame must be ignored
	task automatic erase(input logic [31:0] data, input int nbits, input logic [2:0] k,
		input int len);
		int s0;
		int b0;
		s0 = n_start;
		b0 = busy_cyc;
		send(data, nbits, 40);
		wait_idle();
		chk("erase_start_count", (len > 0), n_start - s0);
		chk("busy_cycles", len, busy_cyc - b0);
		if (len > 0) begin
			chk("erase_kind", k, kind);
			chk("erase_fill", 8'hFF, fill);
			chk("write_enable_latch", 0, write_enable_latch);
			if (k != 3'h4) chk("erase_addr", data[23:0], addr);
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("standby", 1, stby);
		chk("deep_sleep", 0, sleep);
		erase(32'h2000_1000, 32, 3'h0, 0);
		write_enable_cmd();
		erase(32'h2001_2345, 32, 3'h1, 20);
		write_enable_cmd();
		erase(32'h5201_8000, 32, 3'h2, 24);
		sfe_host_model_inst.gap_r = 2;
		write_enable_cmd();
		erase(32'hD800_0100, 32, 3'h3, 28);
		sfe_host_model_inst.gap_r = 0;
		write_enable_cmd();
		erase(32'h0000_00C7, 8, 3'h4, 200);
		write_enable_cmd();
		erase(32'h0000_0060, 8, 3'h4, 200);
		write_enable_cmd();
		erase(32'h1000_91A2, 31, 3'h0, 0);
		erase(32'h0000_C77C, 16, 3'h0, 0);
		mask = 6'h02;
		erase(32'h2000_8000, 32, 3'h0, 0);
		mask = 6'h00;
		prot = 4'h1;
		erase(32'h0000_00C7, 8, 3'h0, 0);
		prot = 4'h0;
		write_enable_cmd();
		send(32'h0000_00C7, 8, 2);
		send(32'h0000_00B9, 8, 40);
		chk("deep_sleep", 0, sleep);
		chk("busy_flag", 1, busy);
		wait_idle();
		send(32'h0000_00B9, 8, 20);
		chk("deep_sleep", 0, sleep);
		repeat (20) @(negedge clk);
		chk("deep_sleep", 1, sleep);
		send(32'h0000_0006, 8, 40);
		chk("write_enable_latch", 0, write_enable_latch);
		send(32'h0000_0066, 8, 40);
		send(32'h0000_0099, 8, 40);
		chk("deep_sleep", 1, sleep);
		send(32'h0000_00AB, 8, 40);
		chk("deep_sleep", 0, sleep);
		chk("standby", 1, stby);
		send(32'h0000_0038, 8, 40);
		chk("quad_mode", 1, quad);
		sfe_host_model_inst.quad_r = 1'b1;
		write_enable_cmd();
		erase(32'h2001_0000, 32, 3'h1, 20);
		give_verdict();
	end
endmodule
